// ===== hw/mec_pkg.sv
// package: constants, field layout and syndrome table of the memory error corrector
package mec_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int MEC_DATA_W = 32;
	localparam int MEC_CHK_W = 7;
	localparam int MEC_ADDR_W = 20;
	localparam int MEC_DW_W = 19;
	localparam logic [MEC_DW_W-1:0] MEC_DW_TOP_DEF = 19'h7FFFF;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int MEC_CLK_MHZ = 100;
	localparam int MEC_SNIFF_NS = 225;
	localparam int MEC_CORR_NS = 225;
	localparam int MEC_SNIFF_CYC = (MEC_SNIFF_NS * MEC_CLK_MHZ + 999) / 1000;
	localparam int MEC_CORR_CYC = (MEC_CORR_NS * MEC_CLK_MHZ + 999) / 1000;
	localparam int MEC_CNT_W = 6;

	// ----------------------------------------------------------------
	// i/o bus functions and flag commands
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MEC_FN_NONE = 2'h0,
		MEC_FN_OUT_A = 2'h1,
		MEC_FN_IN_A = 2'h2,
		MEC_FN_IN_B = 2'h3
	} mec_fn_t;
	typedef enum logic [1:0] {
		MEC_FL_NONE = 2'h0,
		MEC_FL_START = 2'h1,
		MEC_FL_CLEAR = 2'h2,
		MEC_FL_PULSE = 2'h3
	} mec_flag_t;

	// mode word, vector index = 15 - accumulator bit
	localparam int MEC_B_SCRUB_IRQ = 3;
	localparam int MEC_B_SCRUB_DIS = 2;
	localparam int MEC_B_CHECK_EN = 1;
	localparam int MEC_B_CHECK_IRQ = 0;
	// fault code word
	localparam int MEC_B_SYN_MSB = 15;
	localparam int MEC_B_SCRUB_ERR = 8;
	localparam int MEC_B_AHI_MSB = 3;

	// ----------------------------------------------------------------
	// syndrome of a single failing data bit; syn[k] = code bit k
	// ----------------------------------------------------------------
	localparam logic [6:0] MEC_CODE [32] = '{
		7'h4F, 7'h4A, 7'h52, 7'h54, 7'h57, 7'h58, 7'h5B, 7'h5D,
		7'h23, 7'h25, 7'h26, 7'h29, 7'h2A, 7'h2C, 7'h31, 7'h34,
		7'h0E, 7'h0B, 7'h13, 7'h15, 7'h16, 7'h19, 7'h1A, 7'h1C,
		7'h62, 7'h64, 7'h67, 7'h68, 7'h6B, 7'h6D, 7'h70, 7'h75};
endpackage

// ===== hw/mec_codec.sv
// check code generator and single-error corrector for one double word
`timescale 1ns/1ps
`default_nettype none
module mec_codec
	import mec_pkg::*;
(
	input wire logic [MEC_DATA_W-1:0] data,
	input wire logic [MEC_CHK_W-1:0] check,
	output logic [MEC_CHK_W-1:0] gen_check,
	output logic [MEC_CHK_W-1:0] syndrome,
	output logic [MEC_DATA_W-1:0] fixed_data,
	output logic [MEC_CHK_W-1:0] fixed_check,
	output logic single_err,
	output logic multi_err
);
	function automatic logic [MEC_CHK_W-1:0] mec_gen(
		input logic [MEC_DATA_W-1:0] d);
		logic [MEC_CHK_W-1:0] c;
		c = '0;
		for (int i = 0; i < MEC_DATA_W; i++) begin
			if (d[i]) begin
				c = c ^ MEC_CODE[i];
			end
		end
		return c;
	endfunction

	logic [MEC_DATA_W-1:0] hit_d;
	logic [MEC_CHK_W-1:0] hit_c;

	// ----------------------------------------------------------------
	// lookup of the failing bit
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < MEC_DATA_W; g++) begin : g_dbit
			assign hit_d[g] = (syndrome == MEC_CODE[g]); // see R7
		end
		for (g = 0; g < MEC_CHK_W; g++) begin : g_cbit
			assign hit_c[g] = (syndrome == (7'h01 << g)); // see R7
		end
	endgenerate

	assign gen_check = mec_gen(data); // see R18
	assign syndrome = gen_check ^ check;
	assign single_err = (|hit_d) | (|hit_c);
	assign multi_err = (syndrome != '0) && !single_err; // see R18
	assign fixed_data = data ^ hit_d; // see R18
	// an uncorrectable word keeps its old code so the fault stays visible
	assign fixed_check = single_err ? mec_gen(fixed_data) : check;
endmodule
`default_nettype wire

// ===== hw/mec_corrector.sv
// top of the memory error corrector: i/o bus device, check path, scrubber
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: fault-code word: syndrome in bits 0-6, high address in 12-15, rest zero.
// R2: fault-code bit 7 is set when the error was found while scrubbing.
// R3: fault-address word returns the sixteen low physical address bits.
// R4: software trusts captured address and syndrome only while Done is 1.
// R5: address is first word of double word, or quad block on cache fill.
// R6: scrub errors always capture the double-word address.
// R7: syndrome decode follows the fixed 7-bit failing-bit table.
// R8: after power-up checking and scrubbing are on, interrupts off.
// R9: power-up sweep rewrites every double word with fresh check code first.
// R10: normal reads add no delay; each scrub takes an extra 225 ns.
// R11: correcting a double word costs a further 225 ns in either mode.
// R12: software disables or re-enables checking and scrubbing via mode word.
// R13: scrub interrupts only together with check interrupts, never alone.
// R14: no priority mask bit; the request cannot be masked there.
// R15: mode bits: 12 scrub irq, 13 scrub off, 14 check, 15 Done/irq.
// R16: with Done enabled an error sets Done and raises an interrupt.
// R17: start flag clears Done and request; clear and pulse do nothing.
// R18: writes get a 7-bit code per 32 bits; single fixed, double detected.
// R19: captured fault data holds while Done is set.
module mec_corrector
	import mec_pkg::*;
#(
	parameter logic [MEC_DW_W-1:0] MEM_DW_TOP = MEC_DW_TOP_DEF
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic io_reset_all,
	input wire logic io_strobe,
	input wire logic [1:0] io_func,
	input wire logic [1:0] io_flag,
	input wire logic [15:0] io_wdata,
	output logic [15:0] io_rdata,
	output logic io_rvalid,
	output logic done,
	output logic irq_req,
	input wire logic [MEC_DATA_W-1:0] wr_data,
	output logic [MEC_CHK_W-1:0] wr_check,
	input wire logic rd_valid,
	input wire logic rd_quad,
	input wire logic [MEC_ADDR_W-1:0] rd_addr,
	input wire logic [MEC_DATA_W-1:0] rd_data,
	input wire logic [MEC_CHK_W-1:0] rd_check,
	output logic [MEC_DATA_W-1:0] rd_data_out,
	output logic rd_wait,
	input wire logic refresh_tick,
	output logic init_busy,
	output logic scrub_busy,
	output logic mem_req,
	output logic mem_we,
	output logic [MEC_ADDR_W-1:0] mem_addr,
	output logic [MEC_DATA_W-1:0] mem_wdata,
	output logic [MEC_CHK_W-1:0] mem_wcheck,
	input wire logic mem_gnt,
	input wire logic [MEC_DATA_W-1:0] mem_rdata,
	input wire logic [MEC_CHK_W-1:0] mem_rcheck
);
	generate
		if (MEM_DW_TOP == '0) begin : g_bad
			$error("mec_corrector: MEM_DW_TOP must be above zero");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_INIT_RD = 3'h0,
		ST_INIT_WR = 3'h1,
		ST_IDLE = 3'h2,
		ST_SN_RD = 3'h3,
		ST_SN_WAIT = 3'h4,
		ST_SN_WR = 3'h5
	} mec_st_t;

	typedef struct packed {
		mec_st_t st;
		logic [MEC_DW_W-1:0] ptr;
		logic [MEC_CNT_W-1:0] cnt;
		logic [MEC_CNT_W-1:0] rd_cnt;
		logic scrub_irq;
		logic scrub_dis;
		logic check_en;
		logic check_irq;
		logic done;
		logic [MEC_ADDR_W-1:0] fa;
		logic [MEC_CHK_W-1:0] syn;
		logic se;
		logic [15:0] rdata;
		logic rvalid;
		logic [MEC_DATA_W-1:0] bdata;
		logic [MEC_CHK_W-1:0] bcheck;
	} mec_state_t;

	localparam logic [MEC_CNT_W-1:0] SNIFF_CNT = MEC_CNT_W'(MEC_SNIFF_CYC);
	localparam logic [MEC_CNT_W-1:0] CORR_CNT = MEC_CNT_W'(MEC_CORR_CYC);

	mec_state_t s_r;
	mec_state_t s_nxt;

	logic [MEC_CHK_W-1:0] rd_syn;
	logic [MEC_DATA_W-1:0] rd_fix;
	logic rd_single;
	logic [MEC_CHK_W-1:0] m_syn;
	logic [MEC_DATA_W-1:0] m_fix;
	logic [MEC_CHK_W-1:0] m_fixc;
	logic m_single;
	logic [MEC_CHK_W-1:0] wr_check_b;

	// ----------------------------------------------------------------
	// codecs: write path, processor read path, scrub read path
	// ----------------------------------------------------------------
	mec_codec u_wr (
		.data(wr_data), .check('0), .gen_check(wr_check), .syndrome(),
		.fixed_data(), .fixed_check(), .single_err(), .multi_err()
	);
	mec_codec u_rd (
		.data(rd_data), .check(rd_check), .gen_check(), .syndrome(rd_syn),
		.fixed_data(rd_fix), .fixed_check(), .single_err(rd_single),
		.multi_err()
	);
	mec_codec u_mem (
		.data(mem_rdata), .check(mem_rcheck), .gen_check(),
		.syndrome(m_syn), .fixed_data(m_fix), .fixed_check(m_fixc),
		.single_err(m_single), .multi_err()
	);

	logic rd_err;
	logic sn_err;
	logic clr_done;
	logic [MEC_ADDR_W-1:0] rd_base;

	assign rd_err = rd_valid && s_r.check_en && (rd_syn != '0);
	assign sn_err = (s_r.st == ST_SN_RD) && mem_gnt && (m_syn != '0);
	assign clr_done = io_strobe && (io_flag == MEC_FL_START); // see R17
	// cache fill reports the quad block, else the double word
	assign rd_base = rd_quad ? {rd_addr[MEC_ADDR_W-1:2], 2'h0}
		: {rd_addr[MEC_ADDR_W-1:1], 1'h0}; // see R5

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		if (s_r.rd_cnt != '0) begin
			s_nxt.rd_cnt = s_r.rd_cnt - 1'b1;
		end
		if (rd_valid && s_r.check_en && rd_single) begin
			s_nxt.rd_cnt = CORR_CNT; // see R11
		end
		// sweep, then scrub on refresh
		case (s_r.st)
			ST_INIT_RD: begin
				if (mem_gnt) begin
					s_nxt.bdata = mem_rdata;
					s_nxt.st = ST_INIT_WR;
				end
			end
			ST_INIT_WR: begin
				if (mem_gnt) begin
					s_nxt.ptr = (s_r.ptr == MEM_DW_TOP) ? '0 : s_r.ptr + 1'b1;
					s_nxt.st = (s_r.ptr == MEM_DW_TOP) ? ST_IDLE
						: ST_INIT_RD; // see R9
				end
			end
			ST_IDLE: begin
				if (refresh_tick && s_r.check_en && !s_r.scrub_dis) begin
					s_nxt.st = ST_SN_RD; // see R12
				end
			end
			ST_SN_RD: begin
				if (mem_gnt) begin
					s_nxt.bdata = m_fix;
					s_nxt.bcheck = m_fixc;
					s_nxt.cnt = m_single ? SNIFF_CNT + CORR_CNT
						: SNIFF_CNT; // see R10 see R11
					s_nxt.st = ST_SN_WAIT;
				end
			end
			ST_SN_WAIT: begin
				s_nxt.cnt = s_r.cnt - 1'b1;
				if (s_r.cnt == MEC_CNT_W'(1)) begin
					s_nxt.st = ST_SN_WR;
				end
			end
			ST_SN_WR: begin
				if (mem_gnt) begin
					s_nxt.ptr = (s_r.ptr == MEM_DW_TOP) ? '0 : s_r.ptr + 1'b1;
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// fault capture, frozen while Done stands unless cleared now
		if ((rd_err || sn_err) && (!s_r.done || clr_done)) begin
			s_nxt.syn = rd_err ? rd_syn : m_syn; // see R1 see R19
			s_nxt.se = !rd_err; // see R2
			s_nxt.fa = rd_err ? rd_base : {s_r.ptr, 1'h0}; // see R6
		end
		if (clr_done) begin
			s_nxt.done = 1'b0; // see R17
		end
		// set wins over a clear in the same cycle
		if ((rd_err && s_r.check_irq)
				|| (sn_err && s_r.check_irq && s_r.scrub_irq)) begin
			s_nxt.done = 1'b1; // see R13 see R16
		end
		if (io_strobe && (io_func == MEC_FN_OUT_A)) begin
			s_nxt.scrub_irq = io_wdata[MEC_B_SCRUB_IRQ]; // see R15
			s_nxt.scrub_dis = io_wdata[MEC_B_SCRUB_DIS];
			s_nxt.check_en = io_wdata[MEC_B_CHECK_EN];
			s_nxt.check_irq = io_wdata[MEC_B_CHECK_IRQ];
		end
		if (io_strobe && (io_func == MEC_FN_IN_A)) begin
			s_nxt.rdata = s_r.fa[15:0]; // see R3
			s_nxt.rvalid = 1'b1;
		end
		if (io_strobe && (io_func == MEC_FN_IN_B)) begin
			s_nxt.rdata = '0;
			s_nxt.rdata[MEC_B_SYN_MSB -: MEC_CHK_W] = {<<{s_r.syn}}; // see R1
			s_nxt.rdata[MEC_B_SCRUB_ERR] = s_r.se; // see R2
			s_nxt.rdata[MEC_B_AHI_MSB -: 4] = s_r.fa[MEC_ADDR_W-1 -: 4];
			s_nxt.rvalid = 1'b1;
		end
		if (io_reset_all) begin
			s_nxt.scrub_irq = 1'b0; // see R8
			s_nxt.scrub_dis = 1'b0;
			s_nxt.check_en = 1'b1;
			s_nxt.check_irq = 1'b0;
			s_nxt.done = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.st <= ST_INIT_RD;
			s_r.check_en <= 1'b1; // see R8
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs; the request has no priority mask input
	// ----------------------------------------------------------------
	assign io_rdata = s_r.rdata;
	assign io_rvalid = s_r.rvalid;
	assign done = s_r.done;
	assign irq_req = s_r.done; // see R14
	assign rd_data_out = s_r.check_en ? rd_fix : rd_data; // see R10
	assign rd_wait = (s_r.rd_cnt != '0);
	assign init_busy = (s_r.st == ST_INIT_RD) || (s_r.st == ST_INIT_WR);
	assign scrub_busy = (s_r.st == ST_SN_RD) || (s_r.st == ST_SN_WAIT)
		|| (s_r.st == ST_SN_WR);
	assign mem_req = init_busy || (s_r.st == ST_SN_RD) || (s_r.st == ST_SN_WR);
	assign mem_we = (s_r.st == ST_INIT_WR) || (s_r.st == ST_SN_WR);
	assign mem_addr = {s_r.ptr, 1'h0};
	assign mem_wdata = s_r.bdata;
	assign mem_wcheck = (s_r.st == ST_INIT_WR) ? wr_check_b : s_r.bcheck;

	mec_codec u_init (
		.data(s_r.bdata), .check('0), .gen_check(wr_check_b),
		.syndrome(), .fixed_data(), .fixed_check(), .single_err(),
		.multi_err()
	);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_done_sets: assert property (@(posedge clk) disable iff (!rst_n) // see R16
		(rd_err && s_r.check_irq && !io_reset_all) |=> done)
		else $error("done not set after check error");
	a_scrub_alone: assert property (@(posedge clk) disable iff (!rst_n) // see R13
		(sn_err && !s_r.check_irq && !s_r.done) |=> !done)
		else $error("scrub error raised done without check irq");
	a_start_clr: assert property (@(posedge clk) disable iff (!rst_n) // see R17
		(clr_done && !rd_err && !sn_err) |=> !done && !irq_req)
		else $error("start flag did not clear done");
	a_hold_fault: assert property (@(posedge clk) disable iff (!rst_n) // see R19
		(done && !clr_done) |=> $stable(s_r.fa) && $stable(s_r.syn))
		else $error("fault capture changed while done");
	a_read_b_fmt: assert property (@(posedge clk) disable iff (!rst_n) // see R1
		(io_strobe && io_func == MEC_FN_IN_B) |=> io_rvalid
		&& io_rdata[7:4] == 4'h0 && io_rdata[3:0] == $past(s_r.fa[19:16]))
		else $error("fault code word malformed");
	a_read_a_val: assert property (@(posedge clk) disable iff (!rst_n) // see R3
		(io_strobe && io_func == MEC_FN_IN_A) |=> io_rdata == $past(s_r.fa[15:0]))
		else $error("fault address word wrong");
	a_quad_addr: assert property (@(posedge clk) disable iff (!rst_n) // see R5
		(rd_err && rd_quad && !done && !io_reset_all) |=> s_r.fa[1:0] == 2'h0)
		else $error("quad fault address not block aligned");
	a_scrub_flag: assert property (@(posedge clk) disable iff (!rst_n) // see R6
		(sn_err && !rd_err && !done) |=> s_r.se && s_r.fa[0] == 1'b0)
		else $error("scrub capture wrong");
	// cycle counters for the long waits, too long to unroll in a sequence
	logic [7:0] sn_gap_r;
	logic sn_fix_r;
	logic [7:0] rd_run_r;
	logic corr_now;
	assign corr_now = rd_valid && s_r.check_en && rd_single;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sn_gap_r <= 8'h00;
			sn_fix_r <= 1'b0;
			rd_run_r <= 8'h00;
		end else begin
			sn_gap_r <= (s_r.st == ST_SN_WAIT) ? sn_gap_r + 8'h01 : 8'h00;
			if ((s_r.st == ST_SN_RD) && mem_gnt) begin
				sn_fix_r <= m_single;
			end
			rd_run_r <= (corr_now || !rd_wait) ? 8'h00 : rd_run_r + 8'h01;
		end
	end
	a_sniff_time: assert property (@(posedge clk) disable iff (!rst_n) // see R10
		(s_r.st == ST_SN_WR && $past(s_r.st) == ST_SN_WAIT && !sn_fix_r)
		|-> sn_gap_r == 8'(MEC_SNIFF_CYC))
		else $error("sniff delay not 225 ns");
	a_sniff_fix: assert property (@(posedge clk) disable iff (!rst_n) // see R11
		(s_r.st == ST_SN_WR && $past(s_r.st) == ST_SN_WAIT && sn_fix_r)
		|-> sn_gap_r == 8'(MEC_SNIFF_CYC + MEC_CORR_CYC))
		else $error("corrected sniff delay wrong");
	a_corr_wait: assert property (@(posedge clk) disable iff (!rst_n) // see R11
		corr_now |=> rd_wait)
		else $error("correction wait did not start");
	a_corr_len: assert property (@(posedge clk) disable iff (!rst_n) // see R11
		(rd_wait && !corr_now)
		|=> (rd_wait == (rd_run_r < 8'(MEC_CORR_CYC))))
		else $error("correction wait length wrong");
	a_init_first: assert property (@(posedge clk) disable iff (!rst_n) // see R9
		init_busy |-> mem_req && mem_addr[0] == 1'b0)
		else $error("sweep left memory idle");
	a_io_reset_all_mode: assert property (@(posedge clk) disable iff (!rst_n) // see R8
		io_reset_all |=> s_r.check_en && !s_r.scrub_dis && !s_r.check_irq)
		else $error("reset mode wrong");

	c_check_err: cover property (@(posedge clk) disable iff (!rst_n)
		rd_err && s_r.check_irq);
	c_scrub_err: cover property (@(posedge clk) disable iff (!rst_n)
		sn_err && s_r.scrub_irq);
	c_init_done: cover property (@(posedge clk) disable iff (!rst_n)
		init_busy ##1 !init_busy);
endmodule
`default_nettype wire

// ===== hw/mec_unused_placeholder_never.sv
// no content
`timescale 1ns/1ps

// ===== verif/mec_mem_model.sv
// memory array model on the sweep and scrub port of the corrector
`timescale 1ns/1ps
`default_nettype none
module mec_mem_model (
	input wire logic clk,
	input wire logic [3:0] delay,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [19:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [6:0] mem_wcheck,
	output logic mem_gnt,
	output logic [31:0] mem_rdata,
	output logic [6:0] mem_rcheck
);
	logic [31:0] mem_d [8];
	logic [6:0] mem_c [8];
	logic [3:0] w;
	logic armed;
	logic order_ok;
	int wr_cnt;
	int gap;
	logic [19:0] last_raddr;
	initial begin
		w = 4'h0;
		armed = 1'b0;
		order_ok = 1'b1;
		wr_cnt = 0;
		gap = 0;
		mem_gnt = 1'b0;
		mem_rdata = 32'h0;
		mem_rcheck = 7'h0;
		for (int i = 0; i < 8; i++) begin
			mem_d[i] = 32'hA5A50000 + i;
			mem_c[i] = 7'h7F;
		end
	end
	// released read lines show the inverse of the last value
	always @(posedge clk) begin
		mem_gnt <= 1'b0;
		mem_rdata <= ~mem_rdata;
		mem_rcheck <= ~mem_rcheck;
		if (armed && !mem_req)
			gap <= gap + 1;
		if (mem_req && mem_gnt) begin
			w <= 4'h0;
			if (mem_we) begin
				mem_d[mem_addr[3:1]] <= mem_wdata;
				mem_c[mem_addr[3:1]] <= mem_wcheck;
				armed <= 1'b0;
				if (wr_cnt < 8 && mem_addr !== 20'(wr_cnt * 2))
					order_ok <= 1'b0;
				wr_cnt <= wr_cnt + 1;
			end else begin
				armed <= 1'b1;
				gap <= 0;
				last_raddr <= mem_addr;
			end
		end else if (mem_req && w < delay) begin
			w <= w + 4'h1;
		end else if (mem_req) begin
			mem_gnt <= 1'b1;
			mem_rdata <= mem_d[mem_addr[3:1]];
			mem_rcheck <= mem_c[mem_addr[3:1]];
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb_memory_error_check_correct.sv
// testbench of the memory error corrector
`timescale 1ns/1ps
`default_nettype none
module tb_memory_error_check_correct
	import mec_pkg::*;
;
	logic clk, rst_n = 0, io_reset_all = 0, io_strobe = 0;
	logic rd_valid = 0, rd_quad = 0, refresh_tick = 0;
	logic [1:0] io_func = 2'h0, io_flag = 2'h0;
	logic [15:0] io_wdata = 16'h0000, io_rdata;
	logic io_rvalid, done, irq_req, rd_wait, init_busy, scrub_busy;
	logic mem_req, mem_we, mem_gnt;
	logic [31:0] wr_data = 32'h0, rd_data = 32'h0;
	logic [31:0] rd_data_out, mem_wdata, mem_rdata;
	logic [6:0] wr_check, rd_check = 7'h0, mem_wcheck, mem_rcheck;
	logic [19:0] rd_addr = 20'h0, mem_addr;
	logic [3:0] mem_delay = 4'h0;
	logic [31:0] orig [8];
	int errors = 0, checks_done = 0, cyc = 0;

	mec_corrector #(.MEM_DW_TOP(19'h7)) DUT (.clk, .rst_n, .io_reset_all,
		.io_strobe, .io_func, .io_flag, .io_wdata, .io_rdata, .io_rvalid,
		.done, .irq_req, .wr_data, .wr_check, .rd_valid, .rd_quad, .rd_addr,
		.rd_data, .rd_check, .rd_data_out, .rd_wait, .refresh_tick,
		.init_busy, .scrub_busy, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_wcheck, .mem_gnt, .mem_rdata, .mem_rcheck);
	mec_mem_model u_mem (.clk, .delay(mem_delay), .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_wcheck, .mem_gnt, .mem_rdata,
		.mem_rcheck);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------
	// helpers
	// ------
	task automatic summarize;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			summarize;
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [6:0] code(input logic [31:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 0; i < 32; i++)
			if (d[i])
				c ^= MEC_CODE[i];
		return c;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic io(input logic [1:0] fn, fl, input logic [15:0] wd);
		io_strobe = 1'b1;
		io_func = fn;
		io_flag = fl;
		io_wdata = wd;
		step(1);
		io_strobe = 1'b0;
		io_func = 2'h0;
		io_flag = 2'h0;
		if (fn[1])
			check("io_rvalid", io_rvalid, 1'b1);
		step(1);
	endtask
	task automatic rd(input logic [19:0] a, input logic q,
		input logic [31:0] d, df, input logic [6:0] cf, input logic ck);
		step(1);
		rd_valid = 1'b1;
		rd_quad = q;
		rd_addr = a;
		rd_data = d ^ df;
		rd_check = code(d) ^ cf;
		#1;
		if (ck)
			check("rd_data_out", rd_data_out, d);
		step(1);
		rd_valid = 1'b0;
	endtask
	// checks that done is set, then reads the captured fault
	task automatic fault(input logic [19:0] fa, input logic [6:0] syn,
		input logic se);
		logic [6:0] r;
		for (int k = 0; k < 7; k++)
			r[6 - k] = syn[k];
		check("done_valid", done, 1'b1);
		io(MEC_FN_IN_A, MEC_FL_NONE, 16'h0000);
		check("fault_low", io_rdata, fa[15:0]);
		io(MEC_FN_IN_B, MEC_FL_NONE, 16'h0000);
		check("fault_code", io_rdata, {r, se, 4'h0, fa[19:16]});
	endtask
	task automatic scrub;
		refresh_tick = 1'b1;
		step(1);
		refresh_tick = 1'b0;
		for (int i = 0; i < 300 && scrub_busy !== 1'b0; i++)
			step(1);
	endtask

	// ------
	// scenarios
	// ------
	task automatic t_power;
		for (int i = 0; i < 3000 && init_busy !== 1'b0; i++)
			step(1);
		check("init_busy", init_busy, 1'b0);
		check("sweep_order", u_mem.order_ok, 1'b1);
		for (int i = 0; i < 8; i++) begin
			check("swept_data", u_mem.mem_d[i], 32'hA5A50000 + i);
			check("swept_code", u_mem.mem_c[i], code(u_mem.mem_d[i]));
			orig[i] = u_mem.mem_d[i];
		end
		wr_data = 32'hCAFE0001;
		#1;
		check("wr_check", wr_check, code(wr_data));
		rd(20'h00010, 1'b0, 32'h12345678, 32'h1, 7'h0, 1'b1);
		check("done_off", done, 1'b0);
		step(24);
	endtask
	task automatic t_syn;
		logic [19:0] a;
		logic q;
		io(MEC_FN_OUT_A, MEC_FL_NONE, 16'h0003);
		for (int b = 0; b < 39; b++) begin
			a = 20'hF0000 | 20'(b * 1237);
			q = b[0];
			rd(a, q, 32'h5A5AC3C3, b < 32 ? 32'h1 << b : 32'h0,
				b < 32 ? 7'h0 : 7'h1 << (b - 32), 1'b1);
			check("done", done, 1'b1);
			check("irq_req", irq_req, 1'b1);
			fault(a & (q ? 20'hFFFFC : 20'hFFFFE),
				b < 32 ? MEC_CODE[b] : 7'h1 << (b - 32), 1'b0);
			io(MEC_FN_NONE, MEC_FL_START, 16'h0000);
			check("done_start", irq_req, 1'b0);
			step(24);
		end
	endtask
	task automatic t_err;
		int n;
		rd(20'h12347, 1'b1, 32'h0F0F0F0F, 32'h3, 7'h0, 1'b0);
		check("wait_double", rd_wait, 1'b0);
		rd(20'h00021, 1'b0, 32'h77, 32'h4, 7'h0, 1'b1);
		n = 0;
		while (rd_wait === 1'b1 && n < 100) begin
			n++;
			step(1);
		end
		check("wait_len", n, MEC_CORR_CYC);
		fault(20'h12344, MEC_CODE[0] ^ MEC_CODE[1], 1'b0);
		io(MEC_FN_NONE, MEC_FL_CLEAR, 16'h0000);
		io(MEC_FN_NONE, MEC_FL_PULSE, 16'h0000);
		check("done_cp", done, 1'b1);
		io(MEC_FN_NONE, MEC_FL_START, 16'h0000);
		check("done_s", done, 1'b0);
		rd(20'h00030, 1'b0, 32'h99, 32'h0, 7'h0, 1'b1);
		check("wait_clean", rd_wait, 1'b0);
		io(MEC_FN_OUT_A, MEC_FL_NONE, 16'h0000);
		rd(20'h00040, 1'b0, 32'h0, 32'h8, 7'h0, 1'b0);
		check("raw_out", rd_data_out, 32'h8);
		check("done_idle", done, 1'b0);
	endtask
	task automatic t_scrub;
		int n;
		mem_delay = 4'h3;
		io(MEC_FN_OUT_A, MEC_FL_NONE, 16'h0006);
		n = u_mem.wr_cnt;
		scrub;
		check("scrub_off", u_mem.wr_cnt, n);
		io(MEC_FN_OUT_A, MEC_FL_NONE, 16'h000A);
		scrub;
		check("sniff_gap", u_mem.gap, MEC_SNIFF_CYC);
		for (int i = 0; i < 8; i++)
			u_mem.mem_d[i] ^= 32'h20;
		scrub;
		check("corr_gap", u_mem.gap, MEC_SNIFF_CYC + MEC_CORR_CYC);
		check("scrub_only", done, 1'b0);
		check("fixed", u_mem.mem_d[u_mem.last_raddr[3:1]],
			orig[u_mem.last_raddr[3:1]]);
		io(MEC_FN_OUT_A, MEC_FL_NONE, 16'h000B);
		scrub;
		check("scrub_done", done, 1'b1);
		fault(u_mem.last_raddr & 20'hFFFFE, MEC_CODE[5], 1'b1);
		io_reset_all = 1'b1;
		step(1);
		io_reset_all = 1'b0;
		check("rst_done", irq_req, 1'b0);
		rd(20'h00050, 1'b0, 32'h55, 32'h2, 7'h0, 1'b1);
		check("rst_irq", done, 1'b0);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_power;
		t_syn;
		t_err;
		t_scrub;
		summarize;
	end
endmodule
`default_nettype wire
